// ---- verilog/aoms_regs.vh ----
// Register offsets, field positions and reset values of the trim and magnetic status block
`ifndef AOMS_REGS_VH
`define AOMS_REGS_VH

`define AOMS_ADDR_ACC_X_HI   8'h01
`define AOMS_ADDR_ACC_X_LO   8'h02
`define AOMS_ADDR_ACC_Y_HI   8'h03
`define AOMS_ADDR_ACC_Y_LO   8'h04
`define AOMS_ADDR_ACC_Z_HI   8'h05
`define AOMS_ADDR_ACC_Z_LO   8'h06
`define AOMS_ADDR_TRIM_X     8'h2F
`define AOMS_ADDR_TRIM_Y     8'h30
`define AOMS_ADDR_TRIM_Z     8'h31
`define AOMS_ADDR_MAG_FLAGS  8'h32
`define AOMS_ADDR_MAG_X_HI   8'h33
`define AOMS_ADDR_MAG_X_LO   8'h34
`define AOMS_ADDR_MAG_Y_HI   8'h35
`define AOMS_ADDR_MAG_Y_LO   8'h36
`define AOMS_ADDR_MAG_Z_HI   8'h37
`define AOMS_ADDR_MAG_Z_LO   8'h38

`define AOMS_TRIM_RESET      8'h00
`define AOMS_FLAGS_RESET     8'h00
`define AOMS_RDATA_UNMAPPED  8'h00

`define AOMS_BIT_XDR         0
`define AOMS_BIT_YDR         1
`define AOMS_BIT_ZDR         2
`define AOMS_BIT_ZYXDR       3
`define AOMS_BIT_XOW         4
`define AOMS_BIT_YOW         5
`define AOMS_BIT_ZOW         6
`define AOMS_BIT_ZYXOW       7

`endif

// ---- verilog/aoms_mag_axis.v ----
// One magnetic axis: sample holder with ready and overwrite flags
`timescale 1ns/1ps
`default_nettype none
`include "aoms_regs.vh"

module aoms_mag_axis (
   input  wire        clk,
   input  wire        nrst,
   input  wire        done,
   input  wire [15:0] sample,
   input  wire        hi_rd,
   output reg  [15:0] data_q,
   output reg         rdy_q,
   output reg         ovw_q
);

   always @(posedge clk) begin
      if (!nrst) begin
         data_q <= 16'h0000;
         rdy_q  <= 1'b0;
         ovw_q  <= 1'b0;
      end else begin
         if (done) begin
            data_q <= sample;
         end
         // Set beats a same-cycle high-byte read
         if (done) begin
            rdy_q <= 1'b1; // RULE14
         end else if (hi_rd) begin
            rdy_q <= 1'b0; // RULE14
         end
         if (done && rdy_q) begin
            ovw_q <= 1'b1; // RULE9 RULE11 RULE12
         end else if (hi_rd) begin
            ovw_q <= 1'b0; // RULE10 RULE11 RULE12
         end
      end
   end

endmodule
`default_nettype wire

// ---- verilog/aoms_top.v ----
// Accelerometer offset trim and magnetometer sample status register block
//
// Function
// RULE1: One signed 8-bit trim value per accelerometer axis X, Y, Z.
// RULE2: Each trim unit is 2 mg, range -256 mg to +254 mg.
// RULE3: Trim is added to the raw sample before the acceleration output registers 0x01-0x06.
// RULE4: Trim registers change only in standby; host must enter standby first.
// RULE5: Trim X, Y, Z at 0x2F, 0x30, 0x31, eight bits, read/write, reset zero.
// RULE6: Status at 0x32 read-only, reset zero: overwrite flags 7-4, ready flags 3-0.
// RULE7: Combined overwrite sets when any axis sample is overwritten before retrieval.
// RULE8: Combined overwrite clears once all three magnetic high bytes are read.
// RULE9: Z overwrite sets on new Z sample before old retrieved; new replaces old.
// RULE10: Z overwrite clears on any read of the Z high byte.
// RULE11: Y overwrite sets like Z and clears on Y high-byte read.
// RULE12: X overwrite sets like Z and clears on X high-byte read.
// RULE13: Combined ready shows a full new X, Y, Z set; clears after three high-byte reads.
// RULE14: Axis ready sets on new axis sample, clears on that axis's high-byte read.
// RULE15: Magnetic outputs are 16-bit two's complement, high byte first, at 0x33-0x38.
// RULE16: Trim writes while active are ignored and contents read back unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "aoms_regs.vh"

module aoms_top #(
   parameter ACC_W      = 14,
   parameter TRIM_SHIFT = 3
) (
   input  wire             clk,
   input  wire             nrst,
   input  wire             active_mode,
   input  wire [7:0]       reg_addr,
   input  wire             reg_wr,
   input  wire             reg_rd,
   input  wire [7:0]       reg_wdata,
   output reg  [7:0]       reg_rdata_q,
   input  wire             acc_done,
   input  wire [ACC_W-1:0] acc_raw_x,
   input  wire [ACC_W-1:0] acc_raw_y,
   input  wire [ACC_W-1:0] acc_raw_z,
   output reg  [ACC_W-1:0] acc_out_x_q,
   output reg  [ACC_W-1:0] acc_out_y_q,
   output reg  [ACC_W-1:0] acc_out_z_q,
   input  wire             mag_x_done,
   input  wire             mag_y_done,
   input  wire             mag_z_done,
   input  wire [15:0]      mag_x_sample,
   input  wire [15:0]      mag_y_sample,
   input  wire [15:0]      mag_z_sample,
   output reg  [7:0]       mag_sample_flags_q
);

   localparam SUM_W = ACC_W + 2;
   localparam [SUM_W-1:0] SAT_MAX = {3'b000, {(ACC_W-1){1'b1}}};
   localparam [SUM_W-1:0] SAT_MIN = {3'b111, {(ACC_W-1){1'b0}}};

   reg  [7:0]       accel_trim_x_q;
   reg  [7:0]       accel_trim_y_q;
   reg  [7:0]       accel_trim_z_q;
   reg  [2:0]       hi_seen_q;
   reg              zyx_rdy_q;
   reg              zyx_ovw_q;
   reg  [7:0]       rdata_d;
   reg  [2:0]       hi_seen_d;
   reg              all_read;

   wire             rd_x_hi;
   wire             rd_y_hi;
   wire             rd_z_hi;
   wire [15:0]      mag_x_q;
   wire [15:0]      mag_y_q;
   wire [15:0]      mag_z_q;
   wire [2:0]       rdy_q;
   wire [2:0]       ovw_q;
   wire [2:0]       done_vec;
   wire [2:0]       ovw_evt;
   wire             trim_wr_ok;
   wire [SUM_W-1:0] sum_x;
   wire [SUM_W-1:0] sum_y;
   wire [SUM_W-1:0] sum_z;

   // Left-justified 16-bit view of the acceleration result for the byte registers
   wire [15:0]      acc_x16 = {acc_out_x_q, {(16-ACC_W){1'b0}}};
   wire [15:0]      acc_y16 = {acc_out_y_q, {(16-ACC_W){1'b0}}};
   wire [15:0]      acc_z16 = {acc_out_z_q, {(16-ACC_W){1'b0}}};

   assign rd_x_hi    = reg_rd && (reg_addr == `AOMS_ADDR_MAG_X_HI);
   assign rd_y_hi    = reg_rd && (reg_addr == `AOMS_ADDR_MAG_Y_HI);
   assign rd_z_hi    = reg_rd && (reg_addr == `AOMS_ADDR_MAG_Z_HI);
   assign done_vec   = {mag_z_done, mag_y_done, mag_x_done};
   assign ovw_evt    = done_vec & rdy_q;
   assign trim_wr_ok = reg_wr && !active_mode; // RULE4 RULE16

   // Sign-extend the trim and scale one unit to 2 mg in sample counts
   function [SUM_W-1:0] trim_ext;
      input [7:0] t;
      begin
         trim_ext = {{(SUM_W-8){t[7]}}, t} << TRIM_SHIFT; // RULE1 RULE2
      end
   endfunction

   // Saturate rather than wrap so a large trim cannot flip the sign of the result
   function [ACC_W-1:0] sat;
      input [SUM_W-1:0] s;
      begin
         if (!s[SUM_W-1] && (s > SAT_MAX)) begin
            sat = SAT_MAX[ACC_W-1:0];
         end else if (s[SUM_W-1] && (s < SAT_MIN)) begin
            sat = SAT_MIN[ACC_W-1:0];
         end else begin
            sat = s[ACC_W-1:0];
         end
      end
   endfunction

   assign sum_x = {{2{acc_raw_x[ACC_W-1]}}, acc_raw_x} + trim_ext(accel_trim_x_q); // RULE3
   assign sum_y = {{2{acc_raw_y[ACC_W-1]}}, acc_raw_y} + trim_ext(accel_trim_y_q); // RULE3
   assign sum_z = {{2{acc_raw_z[ACC_W-1]}}, acc_raw_z} + trim_ext(accel_trim_z_q); // RULE3

   aoms_mag_axis u_axis_x (
      .clk    (clk),
      .nrst   (nrst),
      .done   (mag_x_done),
      .sample (mag_x_sample),
      .hi_rd  (rd_x_hi),
      .data_q (mag_x_q),
      .rdy_q  (rdy_q[0]),
      .ovw_q  (ovw_q[0])
   );

   aoms_mag_axis u_axis_y (
      .clk    (clk),
      .nrst   (nrst),
      .done   (mag_y_done),
      .sample (mag_y_sample),
      .hi_rd  (rd_y_hi),
      .data_q (mag_y_q),
      .rdy_q  (rdy_q[1]),
      .ovw_q  (ovw_q[1])
   );

   aoms_mag_axis u_axis_z (
      .clk    (clk),
      .nrst   (nrst),
      .done   (mag_z_done),
      .sample (mag_z_sample),
      .hi_rd  (rd_z_hi),
      .data_q (mag_z_q),
      .rdy_q  (rdy_q[2]),
      .ovw_q  (ovw_q[2])
   );

   // Trim registers
   always @(posedge clk) begin
      if (!nrst) begin
         accel_trim_x_q <= `AOMS_TRIM_RESET; // RULE5
         accel_trim_y_q <= `AOMS_TRIM_RESET;
         accel_trim_z_q <= `AOMS_TRIM_RESET;
      end else if (trim_wr_ok) begin
         if (reg_addr == `AOMS_ADDR_TRIM_X) begin
            accel_trim_x_q <= reg_wdata; // RULE5
         end else if (reg_addr == `AOMS_ADDR_TRIM_Y) begin
            accel_trim_y_q <= reg_wdata; // RULE5
         end else if (reg_addr == `AOMS_ADDR_TRIM_Z) begin
            accel_trim_z_q <= reg_wdata; // RULE5
         end
      end
   end

   // Acceleration results, trim applied on capture
   always @(posedge clk) begin
      if (!nrst) begin
         acc_out_x_q <= {ACC_W{1'b0}};
         acc_out_y_q <= {ACC_W{1'b0}};
         acc_out_z_q <= {ACC_W{1'b0}};
      end else if (acc_done) begin
         acc_out_x_q <= sat(sum_x); // RULE3
         acc_out_y_q <= sat(sum_y); // RULE3
         acc_out_z_q <= sat(sum_z); // RULE3
      end
   end

   // High-byte reads since the last full set; restarted when all three are in
   always @* begin
      hi_seen_d = hi_seen_q | {rd_z_hi, rd_y_hi, rd_x_hi};
      all_read  = &hi_seen_d;
      if (all_read) begin
         hi_seen_d = 3'b000;
      end
   end

   // Combined flags
   always @(posedge clk) begin
      if (!nrst) begin
         hi_seen_q <= 3'b000;
         zyx_rdy_q <= 1'b0;
         zyx_ovw_q <= 1'b0;
      end else begin
         hi_seen_q <= hi_seen_d;
         // Set wins over the clear by the third high-byte read
         if ((|done_vec) && (&(rdy_q | done_vec))) begin
            zyx_rdy_q <= 1'b1; // RULE13
         end else if (all_read) begin
            zyx_rdy_q <= 1'b0; // RULE13
         end
         if (|ovw_evt) begin
            zyx_ovw_q <= 1'b1; // RULE7
         end else if (all_read) begin
            zyx_ovw_q <= 1'b0; // RULE8
         end
      end
   end

   // Read mux; unmapped addresses answer zero
   always @* begin
      if (reg_addr == `AOMS_ADDR_ACC_X_HI) begin
         rdata_d = acc_x16[15:8];
      end else if (reg_addr == `AOMS_ADDR_ACC_X_LO) begin
         rdata_d = acc_x16[7:0];
      end else if (reg_addr == `AOMS_ADDR_ACC_Y_HI) begin
         rdata_d = acc_y16[15:8];
      end else if (reg_addr == `AOMS_ADDR_ACC_Y_LO) begin
         rdata_d = acc_y16[7:0];
      end else if (reg_addr == `AOMS_ADDR_ACC_Z_HI) begin
         rdata_d = acc_z16[15:8];
      end else if (reg_addr == `AOMS_ADDR_ACC_Z_LO) begin
         rdata_d = acc_z16[7:0];
      end else if (reg_addr == `AOMS_ADDR_TRIM_X) begin
         rdata_d = accel_trim_x_q; // RULE16
      end else if (reg_addr == `AOMS_ADDR_TRIM_Y) begin
         rdata_d = accel_trim_y_q;
      end else if (reg_addr == `AOMS_ADDR_TRIM_Z) begin
         rdata_d = accel_trim_z_q;
      end else if (reg_addr == `AOMS_ADDR_MAG_FLAGS) begin
         rdata_d = {zyx_ovw_q, ovw_q[2], ovw_q[1], ovw_q[0],
                    zyx_rdy_q, rdy_q[2], rdy_q[1], rdy_q[0]}; // RULE6
      end else if (reg_addr == `AOMS_ADDR_MAG_X_HI) begin
         rdata_d = mag_x_q[15:8]; // RULE15
      end else if (reg_addr == `AOMS_ADDR_MAG_X_LO) begin
         rdata_d = mag_x_q[7:0]; // RULE15
      end else if (reg_addr == `AOMS_ADDR_MAG_Y_HI) begin
         rdata_d = mag_y_q[15:8];
      end else if (reg_addr == `AOMS_ADDR_MAG_Y_LO) begin
         rdata_d = mag_y_q[7:0];
      end else if (reg_addr == `AOMS_ADDR_MAG_Z_HI) begin
         rdata_d = mag_z_q[15:8];
      end else if (reg_addr == `AOMS_ADDR_MAG_Z_LO) begin
         rdata_d = mag_z_q[7:0];
      end else begin
         rdata_d = `AOMS_RDATA_UNMAPPED;
      end
   end

   // Read data and a mirror of the status byte
   always @(posedge clk) begin
      if (!nrst) begin
         reg_rdata_q        <= 8'h00;
         mag_sample_flags_q <= `AOMS_FLAGS_RESET; // RULE6
      end else begin
         if (reg_rd) begin
            reg_rdata_q <= rdata_d;
         end
         mag_sample_flags_q <= {zyx_ovw_q, ovw_q[2], ovw_q[1], ovw_q[0],
                                zyx_rdy_q, rdy_q[2], rdy_q[1], rdy_q[0]};
      end
   end

endmodule
`default_nettype wire

// ---- test/aoms_top_props.sv ----
// Port assertions for the trim and magnetic status block
`timescale 1ns/1ps
`default_nettype none
`include "aoms_regs.vh"
module aoms_top_props #(
   parameter ACC_W = 14
) (
   input wire             clk,
   input wire             nrst,
   input wire [7:0]       reg_addr,
   input wire             reg_rd,
   input wire [7:0]       reg_rdata_q,
   input wire             acc_done,
   input wire [ACC_W-1:0] acc_out_x_q,
   input wire             mag_x_done,
   input wire             mag_y_done,
   input wire             mag_z_done,
   input wire [7:0]       mag_sample_flags_q
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);
   // Status copy lags the flags by one cycle, hence two cycles from a done
   x_ready_set_a: assert property (mag_x_done |-> ##2 mag_sample_flags_q[0])
      else $error("x ready flag not set");
   y_ready_set_a: assert property (mag_y_done |-> ##2 mag_sample_flags_q[1])
      else $error("y ready flag not set");
   z_ready_set_a: assert property (mag_z_done |-> ##2 mag_sample_flags_q[2])
      else $error("z ready flag not set");
   all_ready_set_a: assert property (mag_x_done && mag_y_done && mag_z_done
      |-> ##2 mag_sample_flags_q[3]) else $error("combined ready flag not set");
   x_overwrite_set_a: assert property (mag_x_done ##1 mag_x_done
      |-> ##2 (mag_sample_flags_q[4] && mag_sample_flags_q[7]))
      else $error("x overwrite flags not set");
   z_read_clear_a: assert property (reg_rd && reg_addr == `AOMS_ADDR_MAG_Z_HI
      && !mag_z_done |-> ##2 (!mag_sample_flags_q[2] && !mag_sample_flags_q[6]))
      else $error("z flags not cleared by high byte read");
   status_read_a: assert property (reg_rd && reg_addr == `AOMS_ADDR_MAG_FLAGS
      |=> reg_rdata_q == mag_sample_flags_q) else $error("status read mismatch");
   acc_hold_a: assert property (!acc_done |=> $stable(acc_out_x_q))
      else $error("accel output changed without a sample");
endmodule
bind aoms_top aoms_top_props #(.ACC_W(ACC_W)) props (.clk(clk), .nrst(nrst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .acc_done(acc_done),
   .acc_out_x_q(acc_out_x_q), .mag_x_done(mag_x_done), .mag_y_done(mag_y_done),
   .mag_z_done(mag_z_done), .mag_sample_flags_q(mag_sample_flags_q));
`default_nettype wire

// ---- test/aoms_host.sv ----
// Host model issuing register reads and writes on the strobe port
`timescale 1ns/1ps
`default_nettype none
module aoms_host (
   input  wire        clk,
   input  wire  [7:0] rdata,
   output logic       active,
   output logic [7:0] addr,
   output logic       wr,
   output logic       rd,
   output logic [7:0] wdata
);
   initial begin
      active = 1'b0;
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   // Trim writes only take effect in standby, so the host leaves active first
   task set_mode(input logic m);
      @(posedge clk);
      #1 active = m;
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1 wr = 1'b0;
      wdata = ~d;
   endtask
   task rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1 rd = 1'b0;
      d = rdata;
   endtask
endmodule
`default_nettype wire

// ---- test/aoms_top_test.sv ----
// Self-checking bench for the trim and magnetic status block
`timescale 1ns/1ps
`default_nettype none
`include "aoms_regs.vh"
module aoms_top_test;
   localparam SH = 3;
   logic clk = 1'b0, nrst = 1'b0, acc_done = 1'b0;
   logic [13:0] ax = 14'h0064, ay = 14'h1F40, az = 14'h20C0;
   logic [2:0] md = 3'h0;
   logic [15:0] mx = 16'h1234, my = 16'h8001, mz = 16'h7FFE;
   logic [7:0] tx = 8'hE2, ty = 8'h7F, tz = 8'h80;
   logic [15:0] xe;
   wire [7:0] addr, wdata, rdata, flags;
   wire wr, rd, act;
   wire [13:0] ox, oy, oz;
   integer n_mismatch = 0, comparisons = 0, cyc = 0;
   aoms_top #(.ACC_W(14), .TRIM_SHIFT(SH)) uut (.clk(clk), .nrst(nrst), .active_mode(act),
      .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata_q(rdata),
      .acc_done(acc_done), .acc_raw_x(ax), .acc_raw_y(ay), .acc_raw_z(az),
      .acc_out_x_q(ox), .acc_out_y_q(oy), .acc_out_z_q(oz), .mag_x_done(md[0]),
      .mag_y_done(md[1]), .mag_z_done(md[2]), .mag_x_sample(mx), .mag_y_sample(my),
      .mag_z_sample(mz), .mag_sample_flags_q(flags));
   aoms_host host (.clk(clk), .rdata(rdata), .active(act), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wdata));
   always #12.5 clk = ~clk;
   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         end_sim;
      end
   end
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd_reg(a, d);
      chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, e});
   endtask
   // Samples are inverted after each done so a stale capture cannot match
   task mag(input logic [2:0] m, input integer n);
      @(posedge clk);
      #1 md = m;
      repeat (n) @(posedge clk);
      #1 md = 3'h0;
      {mx, my, mz} = ~{mx, my, mz};
   endtask
   function automatic [15:0] sat(input integer v);
      sat = {2'b00, v > 8191 ? 14'h1FFF : v < -8192 ? 14'h2000 : v[13:0]};
   endfunction
   initial begin
      repeat (12) @(posedge clk);
      #1 nrst = 1'b1;
      rc(`AOMS_ADDR_TRIM_X, 8'h00);
      rc(`AOMS_ADDR_TRIM_Z, 8'h00);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h00);
      $display("test reset values done");
      host.set_mode(1'b0);
      host.wr_reg(`AOMS_ADDR_TRIM_X, tx);
      host.wr_reg(`AOMS_ADDR_TRIM_Y, ty);
      host.wr_reg(`AOMS_ADDR_TRIM_Z, tz);
      host.wr_reg(`AOMS_ADDR_MAG_FLAGS, 8'hFF);
      rc(`AOMS_ADDR_TRIM_X, tx);
      rc(`AOMS_ADDR_TRIM_Y, ty);
      rc(`AOMS_ADDR_TRIM_Z, tz);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h00);
      host.set_mode(1'b1);
      host.wr_reg(`AOMS_ADDR_TRIM_Y, 8'h11);
      rc(`AOMS_ADDR_TRIM_Y, ty);
      $display("test trim access done");
      @(posedge clk);
      #1 acc_done = 1'b1;
      @(posedge clk);
      #1 acc_done = 1'b0;
      xe = sat($signed(ax) + $signed(tx) * (2 ** SH));
      chk("acc x", {2'b00, ox}, xe);
      chk("acc y", {2'b00, oy}, sat($signed(ay) + $signed(ty) * (2 ** SH)));
      chk("acc z", {2'b00, oz}, sat($signed(az) + $signed(tz) * (2 ** SH)));
      rc(`AOMS_ADDR_ACC_X_HI, xe[13:6]);
      rc(`AOMS_ADDR_ACC_X_LO, {xe[5:0], 2'b00});
      $display("test accel trim done");
      mag(3'h7, 1);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h0F);
      mx = 16'hA5C3;
      mag(3'h1, 2);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h9F);
      chk("flag port", {8'h00, flags}, 16'h009F);
      rc(`AOMS_ADDR_MAG_X_HI, 8'hA5);
      rc(`AOMS_ADDR_MAG_X_LO, 8'hC3);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h8E);
      rc(`AOMS_ADDR_MAG_Y_HI, 8'h80);
      rc(`AOMS_ADDR_MAG_Z_HI, 8'h7F);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h00);
      // Two inversions since the first set; flip once more so new Y, Z differ from old
      {my, mz} = ~{my, mz};
      mag(3'h6, 2);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'hE6);
      rc(`AOMS_ADDR_MAG_Z_HI, 8'h80);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'hA2);
      rc(`AOMS_ADDR_MAG_Y_HI, 8'h7F);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h80);
      rc(`AOMS_ADDR_MAG_X_HI, 8'hA5);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h00);
      $display("test magnetic flags done");
      @(posedge clk);
      #1 nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      rc(`AOMS_ADDR_TRIM_X, 8'h00);
      rc(`AOMS_ADDR_TRIM_Y, 8'h00);
      rc(`AOMS_ADDR_MAG_FLAGS, 8'h00);
      $display("test mid-run reset done");
      end_sim;
   end
endmodule
`default_nettype wire
